// *** rtl/lpmwc_host.sv ***
// Function
// - Transmit level before enable picks slew
// - Enable low, data high, held sleeps
// - Data level set up before enable
// - Wait before first transmit after mode
// - Fast toggle sequence within entry window
// - Short enable pulse leaves fast mode
// - Fast entry: both low, data, enable
`timescale 1ns/10ps
`default_nettype none
module lpmwc_host #(
  parameter int unsigned FIRST_TX_CYC = lpmwc_pkg::FIRST_TX_CYC,
  parameter int unsigned SLEEP_CYC = lpmwc_pkg::SLEEP_CYC,
  parameter int unsigned BIT_NORMAL_CYC = lpmwc_pkg::BIT_NORMAL_CYC,
  parameter int unsigned BIT_SLOW_CYC = lpmwc_pkg::BIT_SLOW_CYC
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic cmd_valid, // Mode command request
  input wire logic [2:0] cmd, // Command code
  output logic cmd_ready, // Command accepted when high
  input wire logic tx_valid, // Byte to send
  output logic tx_ready, // FIFO has room
  input wire logic [7:0] tx_data, // Byte, LSB first
  output logic txd_o, // Transmit data pin
  output logic en_o, // Enable pin
  input wire logic rxd, // Receive data pin, pulled up
  input wire logic inhibit_out, // Inhibit pin readback
  output logic rx_level, // Sampled bus level
  output logic wake_evt, // Wake reported, one cycle
  output logic inh_fault, // Inhibit stayed high in sleep
  output logic [3:0] mode, // Current state code
  output logic slow_sel, // Slow slew chosen
  output logic fast_on // Fast rate active
);
  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  lpmwc_pkg::lpmwc_state_t state_q, state_d;
  logic [15:0] cnt_q;
  logic en_q, txd_q, slow_q, fast_q, rx_q, wake_q, fault_q;
  logic [9:0] sh_q;
  logic [3:0] bits_q;
  logic [15:0] btmr_q;
  logic f_valid, f_ready;
  logic [7:0] f_data;

  wire cnt_done = cnt_q == 16'h0000;
  wire tx_busy = bits_q != 4'h0;
  wire idle = (state_q == lpmwc_pkg::ST_ACTIVE) && !tx_busy && !f_valid;
  wire cmd_go = cmd_valid && cmd_ready;
  // Wake filtering and the reference level live in the device
  wire rx_wake = (state_q == lpmwc_pkg::ST_SLEEP) &&
                 !rxd;

  always_comb begin
    state_d = state_q;
    case (state_q)
      lpmwc_pkg::ST_AWAKE, lpmwc_pkg::ST_SLEEP: begin
        if (rx_wake) state_d = lpmwc_pkg::ST_AWAKE;
        else if (cmd_go && (cmd == lpmwc_pkg::CMD_NORMAL ||
                 cmd == lpmwc_pkg::CMD_SLOW)) state_d = lpmwc_pkg::ST_SETUP;
      end
      lpmwc_pkg::ST_SETUP: if (cnt_done) state_d = lpmwc_pkg::ST_WAITCOM;
      lpmwc_pkg::ST_WAITCOM: if (cnt_done) state_d = lpmwc_pkg::ST_ACTIVE;
      lpmwc_pkg::ST_ACTIVE: begin
        if (cmd_go && cmd == lpmwc_pkg::CMD_SLEEP) begin
          state_d = lpmwc_pkg::ST_SLEEPING;
        end else if (cmd_go && cmd == lpmwc_pkg::CMD_FAST) begin
          state_d = lpmwc_pkg::ST_TOG_LOW;
        end else if (cmd_go && cmd == lpmwc_pkg::CMD_FAST_EXIT && fast_q) begin
          state_d = lpmwc_pkg::ST_GLITCH;
        end
      end
      lpmwc_pkg::ST_SLEEPING: if (cnt_done) state_d = lpmwc_pkg::ST_SLEEP;
      lpmwc_pkg::ST_TOG_LOW: if (cnt_done) state_d = lpmwc_pkg::ST_TOG_HIGH;
      lpmwc_pkg::ST_TOG_HIGH: if (cnt_done) state_d = lpmwc_pkg::ST_WAITCOM;
      lpmwc_pkg::ST_GLITCH: if (cnt_done) state_d = lpmwc_pkg::ST_ACTIVE;
      default: state_d = lpmwc_pkg::ST_AWAKE;
    endcase
  end

  // Delay loaded on each state change, counted down to zero
  wire [15:0] cnt_load =
    (state_d == lpmwc_pkg::ST_SETUP) ? 16'(lpmwc_pkg::MS_SETUP_CYC) :
    (state_d == lpmwc_pkg::ST_WAITCOM) ? 16'(FIRST_TX_CYC) :
    (state_d == lpmwc_pkg::ST_SLEEPING) ? 16'(SLEEP_CYC) :
    (state_d == lpmwc_pkg::ST_GLITCH) ? 16'(lpmwc_pkg::GLITCH_CYC) :
    (state_d == lpmwc_pkg::ST_TOG_LOW ||
     state_d == lpmwc_pkg::ST_TOG_HIGH) ? 16'(lpmwc_pkg::TOG_STEP_CYC) :
    16'h0000;

  // Pin levels per state; slew level shown on data before enable
  // A new wake shows its slew level on the data pin in the cycle it is
  // taken, so the setup time runs from that edge and no stale level leaks
  wire wake_go = (state_d == lpmwc_pkg::ST_SETUP) &&
                 (state_q != lpmwc_pkg::ST_SETUP);
  wire slow_d = wake_go ? (cmd == lpmwc_pkg::CMD_SLOW) : slow_q;
  wire en_d = (state_d == lpmwc_pkg::ST_WAITCOM) ||
              (state_d == lpmwc_pkg::ST_ACTIVE);
  wire txd_d =
    (state_d == lpmwc_pkg::ST_SETUP) ? !slow_d :
    (state_d == lpmwc_pkg::ST_WAITCOM) ? txd_q : // Held through enable rise
    (state_d == lpmwc_pkg::ST_TOG_LOW) ? 1'b0 :
    (state_d == lpmwc_pkg::ST_ACTIVE && tx_busy) ? sh_q[0] :
    1'b1;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= lpmwc_pkg::ST_AWAKE;
      cnt_q <= 16'h0000;
      en_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? cnt_load :
               (cnt_done ? cnt_q : cnt_q - 16'h0001);
      en_q <= en_d;
      txd_q <= txd_d;
    end
  end

  // Slew fixed only when leaving sleep or awake; fast toggles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slow_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      if (wake_go) begin
        slow_q <= slow_d;
        fast_q <= 1'b0;
      end
      if (state_q == lpmwc_pkg::ST_TOG_HIGH && cnt_done) begin
        fast_q <= !fast_q;
      end
      if (state_q == lpmwc_pkg::ST_GLITCH && cnt_done) begin
        fast_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Receive level, wake report and inhibit check
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_q <= 1'b1;
      wake_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      rx_q <= rxd;
      wake_q <= rx_wake;
      // Sleep state is at least as late as the inhibit limit
      if (state_q == lpmwc_pkg::ST_SLEEP && inhibit_out) fault_q <= 1'b1;
      else if (state_q == lpmwc_pkg::ST_SETUP) fault_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Byte serializer: start bit, 8 data bits, stop bit
  // ****************************************************************
  wire [15:0] bit_len = fast_q ? 16'(lpmwc_pkg::BIT_FAST_CYC) :
                        slow_q ? 16'(BIT_SLOW_CYC) : 16'(BIT_NORMAL_CYC);
  wire bit_end = tx_busy && btmr_q == 16'h0000;
  assign f_ready = idle ? 1'b0 : (state_q == lpmwc_pkg::ST_ACTIVE && !tx_busy);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 10'h3FF;
      bits_q <= 4'h0;
      btmr_q <= 16'h0000;
    end else if (f_valid && f_ready) begin
      sh_q <= {1'b1, f_data, 1'b0};
      bits_q <= lpmwc_pkg::FRAME_BITS;
      btmr_q <= bit_len - 16'h0001;
    end else if (bit_end) begin
      sh_q <= {1'b1, sh_q[9:1]};
      bits_q <= bits_q - 4'h1;
      btmr_q <= bit_len - 16'h0001;
    end else if (tx_busy) begin
      btmr_q <= btmr_q - 16'h0001;
    end
  end

  lpmwc_fifo #(.W(lpmwc_pkg::DATA_W), .D(lpmwc_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign cmd_ready = (state_q == lpmwc_pkg::ST_AWAKE) ||
                     (state_q == lpmwc_pkg::ST_SLEEP) || idle;
  assign txd_o = txd_q;
  assign en_o = en_q;
  assign rx_level = rx_q;
  assign wake_evt = wake_q;
  assign inh_fault = fault_q;
  assign mode = state_q;
  assign slow_sel = slow_q;
  assign fast_on = fast_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [15:0] lo_cnt_q, hi_cnt_q, stab_cnt_q;
  logic txd_prev_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt_q <= 16'h0000;
      hi_cnt_q <= 16'h0000;
      stab_cnt_q <= 16'h0000;
      txd_prev_q <= 1'b1;
    end else begin
      // Counters saturate so a long idle spell cannot wrap into a false fire
      lo_cnt_q <= en_q ? 16'h0000 : lo_cnt_q + {15'h0000, ~&lo_cnt_q};
      hi_cnt_q <= !en_q ? 16'h0000 : hi_cnt_q + {15'h0000, ~&hi_cnt_q};
      txd_prev_q <= txd_q;
      stab_cnt_q <= (txd_q != txd_prev_q) ? 16'h0000 :
                    stab_cnt_q + {15'h0000, ~&stab_cnt_q};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence tog_low_s;
    !en_q && !txd_q;
  endsequence
  sequence tog_high_s;
    !en_q && txd_q;
  endsequence
  sequence tog_end_s;
    en_q && txd_q;
  endsequence

  mode_setup_a: assert property (
    $rose(en_q) && $past(state_q) == lpmwc_pkg::ST_SETUP
    |-> stab_cnt_q >= 16'(lpmwc_pkg::MS_SETUP_CYC))
    else $error("enable rose before data setup time");
  slew_level_a: assert property (
    $rose(en_q) && $past(state_q) == lpmwc_pkg::ST_SETUP |-> txd_q == !slow_q)
    else $error("data level does not match chosen slew");
  sleep_req_a: assert property (
    state_q == lpmwc_pkg::ST_SLEEPING |-> !en_q && txd_q)
    else $error("sleep request with wrong pin levels");
  sleep_hold_a: assert property (
    $rose(state_q == lpmwc_pkg::ST_SLEEP) |-> lo_cnt_q >= 16'(SLEEP_CYC))
    else $error("sleep reached before filter time");
  first_tx_a: assert property (
    en_q && $fell(txd_q) |-> hi_cnt_q > 16'(FIRST_TX_CYC))
    else $error("transmit started too soon after mode select");
  fast_window_a: assert property (
    $rose(en_q) && $past(state_q) == lpmwc_pkg::ST_TOG_HIGH
    |-> lo_cnt_q <= 16'(lpmwc_pkg::FAST_ENTRY_CYC))
    else $error("fast entry sequence too long");
  // Step lengths are bounded by fast_window_a through lo_cnt_q
  toggle_seq_a: assert property (
    $rose(state_q == lpmwc_pkg::ST_TOG_LOW) |-> tog_low_s [*2])
    else $error("fast entry did not start with both pins low");
  toggle_mid_a: assert property (
    $rose(state_q == lpmwc_pkg::ST_TOG_HIGH) |-> tog_high_s [*2])
    else $error("fast entry data did not rise before enable");
  toggle_end_a: assert property (
    $fell(state_q == lpmwc_pkg::ST_TOG_HIGH) |-> tog_end_s)
    else $error("fast entry did not end with enable high");
  glitch_len_a: assert property (
    $rose(en_q) && $past(state_q) == lpmwc_pkg::ST_GLITCH
    |-> lo_cnt_q <= 16'(lpmwc_pkg::FAST_EXIT_CYC) && !fast_q)
    else $error("fast exit pulse too long");
  wake_rep_a: assert property (
    state_q == lpmwc_pkg::ST_SLEEP && !rxd
    |=> wake_evt && state_q == lpmwc_pkg::ST_AWAKE)
    else $error("wake report missed");
endmodule : lpmwc_host
`default_nettype wire

// *** rtl/lpmwc_pkg.sv ***
package lpmwc_pkg;
  // ****************************************************************
  // Clock and printed times, times in ns
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int MODE_SELECT_SETUP_DELAY_NS = 5000;
  localparam int FIRST_TRANSMIT_DELAY_NS = 50000;
  localparam int SLEEP_ENTRY_DELAY_NS = 50000;
  localparam int INHIBIT_OFF_DELAY_NS = 50000;
  localparam int FAST_ENTRY_WINDOW_NS = 35000;
  localparam int FAST_EXIT_PULSE_NS = 5000;
  localparam int BIT_NORMAL_NS = 50000;
  localparam int BIT_SLOW_NS = 100000;
  localparam int BIT_FAST_NS = 10000;
  // ****************************************************************
  // Cycle counts: least times round up, longest times round down
  // ****************************************************************
  localparam int MS_SETUP_CYC = (MODE_SELECT_SETUP_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIRST_TX_CYC = (FIRST_TRANSMIT_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int INH_OFF_CYC = INHIBIT_OFF_DELAY_NS / CLK_NS;
  localparam int FAST_ENTRY_CYC = FAST_ENTRY_WINDOW_NS / CLK_NS;
  localparam int FAST_EXIT_CYC = FAST_EXIT_PULSE_NS / CLK_NS;
  // Margin: toggle steps use a quarter of the window, glitch half
  localparam int TOG_STEP_CYC = FAST_ENTRY_CYC / 4;
  localparam int GLITCH_CYC = FAST_EXIT_CYC / 2;
  localparam int BIT_NORMAL_CYC = BIT_NORMAL_NS / CLK_NS;
  localparam int BIT_SLOW_CYC = BIT_SLOW_NS / CLK_NS;
  localparam int BIT_FAST_CYC = BIT_FAST_NS / CLK_NS;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;
  localparam logic [3:0] FRAME_BITS = 4'hA;

  typedef enum logic [2:0] {
    CMD_NORMAL = 3'b000,
    CMD_SLOW = 3'b001,
    CMD_SLEEP = 3'b010,
    CMD_FAST = 3'b011,
    CMD_FAST_EXIT = 3'b100
  } lpmwc_cmd_t;

  typedef enum logic [3:0] {
    ST_AWAKE = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_WAITCOM = 4'b0010,
    ST_ACTIVE = 4'b0011,
    ST_SLEEPING = 4'b0100,
    ST_SLEEP = 4'b0101,
    ST_TOG_LOW = 4'b0110,
    ST_TOG_HIGH = 4'b0111,
    ST_GLITCH = 4'b1000
  } lpmwc_state_t;
endpackage : lpmwc_pkg

// *** rtl/lpmwc_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module lpmwc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic mclk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read accept
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lpmwc_fifo
`default_nettype wire

// *** verif/lpmwc_xcvr_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lpmwc_xcvr_model #(
  parameter int SLEEP_N = 6250, // Sleep filter, cycles
  parameter int BUS_N = 8750, // Bus wake filter, cycles
  parameter int WAKE_N = 5000, // Local wake filter, cycles
  parameter int WIN_N = 4375, // Fast entry window, cycles
  parameter int EXIT_N = 625 // Fast exit pulse, cycles
) (
  input wire logic mclk, // Sampling clock
  input wire logic resetn, // Power-up, active low
  input wire logic txd, // Transmit data from host
  input wire logic en, // Enable from host
  input wire logic node_low, // Another node drives dominant
  input wire logic wake_in, // Local wake input
  output logic bus, // Bus level
  output logic inhibit_out, // Inhibit output
  output wire logic rxd // Receive data, floats asleep
);
  logic asleep_q, active_q, slow_q, fast_q, en_q, ref_q, txf_q;
  int lo_q, bw_q, lw_q;
  assign bus = !(active_q && !txd) && !node_low;
  assign rxd = asleep_q ? 1'bz : (active_q ? bus : 1'b0);
  assign inhibit_out = !asleep_q;
  // ********
  // Mode tracking, all filters counted in clock cycles
  // ********
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      asleep_q <= 1'b0;
      active_q <= 1'b0;
      slow_q <= 1'b0;
      fast_q <= 1'b0;
      en_q <= 1'b0;
      ref_q <= 1'b0;
      txf_q <= 1'b1;
      lo_q <= 0;
      bw_q <= 0;
      lw_q <= 0;
    end else begin
      en_q <= en;
      lo_q <= en ? 0 : lo_q + 1;
      bw_q <= (asleep_q && node_low) ? bw_q + 1 : 0;
      lw_q <= (asleep_q && wake_in != ref_q) ? lw_q + 1 : 0;
      if (en_q && !en) txf_q <= txd;
      if (en && !en_q) begin
        active_q <= 1'b1;
        asleep_q <= 1'b0;
        // Slew is latched only on a real wake, so later tries are ignored
        if (asleep_q || !active_q) slow_q <= !txd;
        else if (fast_q && lo_q <= EXIT_N) fast_q <= 1'b0;
        else if (!txf_q && txd && lo_q <= WIN_N) fast_q <= !fast_q;
      end
      if (active_q && !en && txd && lo_q >= SLEEP_N) begin
        asleep_q <= 1'b1;
        active_q <= 1'b0;
        fast_q <= 1'b0;
        ref_q <= wake_in;
      end
      if (bw_q >= BUS_N || lw_q >= WAKE_N) asleep_q <= 1'b0;
    end
  end
endmodule : lpmwc_xcvr_model
`default_nettype wire

// *** verif/lin_phy_mode_and_wake_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module lin_phy_mode_and_wake_control_test;
  typedef struct {
    lpmwc_pkg::lpmwc_cmd_t c; // Wake command
    logic tx; // Transmit level during setup
    logic sl; // Slow slew expected
    int bl; // Bit length, cycles
    logic [7:0] d; // Byte sent
    int np; // Bytes queued before wake
    bit bw; // Wake by bus, else by local input
  } lpmwc_row_t;
  // ********
  // Stimulus and wiring
  // ********
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic node_low = 1'b0;
  logic wake_in = 1'b0;
  logic cmd_ready, tx_ready, txd_o, en_o, inhibit_out, rx_level, wake_evt;
  logic inh_fault, slow_sel, fast_on, bus;
  logic [3:0] mode;
  wire rxd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  lpmwc_row_t rows [2] = '{
    '{lpmwc_pkg::CMD_NORMAL, 1'b1, 1'b0, 20, 8'hA5, 8, 1'b1},
    '{lpmwc_pkg::CMD_SLOW, 1'b0, 1'b1, 40, 8'h3C, 1, 1'b0}};
  pullup (rxd);
  initial begin
    forever #4 mclk = ~mclk;
  end
  lpmwc_host #(.FIRST_TX_CYC(50), .SLEEP_CYC(3000), .BIT_NORMAL_CYC(20),
    .BIT_SLOW_CYC(40)) lpmwc_host_i (.mclk(mclk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .txd_o(txd_o), .en_o(en_o), .rxd(rxd), .inhibit_out(inhibit_out), .rx_level(rx_level),
    .wake_evt(wake_evt), .inh_fault(inh_fault), .mode(mode),
    .slow_sel(slow_sel), .fast_on(fast_on));
  // Sleep filter sits above the toggle sequence but below the host's wait
  // Wake filters keep their full lengths so the real delays are exercised
  lpmwc_xcvr_model #(.SLEEP_N(2500),
    .WIN_N(lpmwc_pkg::FAST_ENTRY_CYC), .EXIT_N(lpmwc_pkg::FAST_EXIT_CYC))
    lpmwc_xcvr_model_i (.mclk(mclk), .resetn(resetn), .txd(txd_o),
    .en(en_o), .node_low(node_low), .wake_in(wake_in), .bus(bus),
    .inhibit_out(inhibit_out), .rxd(rxd));
  // ********
  // Tasks
  // ********
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic send_cmd(input lpmwc_pkg::lpmwc_cmd_t c);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= c;
    do @(negedge mclk); while (cmd_ready !== 1'b1);
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask : send_cmd
  task automatic push(input logic [7:0] d);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge mclk);
    tx_valid <= 1'b0;
  endtask : push
  task automatic wait_mode(input logic [3:0] m);
    do @(negedge mclk); while (mode !== m);
  endtask : wait_mode
  // Samples the bus as the host sees it, in the middle of each bit
  task automatic frame(input logic [7:0] d, input int bl);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    do @(negedge mclk); while (bus !== 1'b0);
    repeat (bl / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      chk(rx_level, fr[i]);
      repeat (bl) @(negedge mclk);
    end
  endtask : frame
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk(mode, lpmwc_pkg::ST_AWAKE);
    chk(inhibit_out, 1'b1);
    chk(rxd, 1'b0);
    foreach (rows[r]) begin
      for (int k = 0; k < rows[r].np; k++) push(rows[r].d);
      @(negedge mclk);
      chk(tx_ready, rows[r].np < 8);
      send_cmd(rows[r].c);
      repeat (2) @(negedge mclk);
      chk(txd_o, rows[r].tx);
      chk(en_o, 1'b0);
      wait_mode(lpmwc_pkg::ST_ACTIVE);
      chk(en_o, 1'b1);
      chk(slow_sel, rows[r].sl);
      frame(rows[r].d, rows[r].bl);
      send_cmd(lpmwc_pkg::CMD_SLEEP);
      wait_mode(lpmwc_pkg::ST_SLEEP);
      chk({en_o, txd_o}, 2'b01);
      chk(inhibit_out, 1'b0);
      chk(inh_fault, 1'b0);
      chk(rxd, 1'b1);
      @(posedge mclk);
      if (rows[r].bw) node_low <= 1'b1;
      else wake_in <= ~wake_in;
      do @(negedge mclk); while (wake_evt !== 1'b1);
      chk(rxd, 1'b0);
      @(posedge mclk);
      node_low <= 1'b0;
      wait_mode(lpmwc_pkg::ST_AWAKE);
    end
    send_cmd(lpmwc_pkg::CMD_NORMAL);
    wait_mode(lpmwc_pkg::ST_ACTIVE);
    send_cmd(lpmwc_pkg::CMD_SLOW);
    repeat (2) @(negedge mclk);
    chk(slow_sel, 1'b0);
    chk(mode, lpmwc_pkg::ST_ACTIVE);
    send_cmd(lpmwc_pkg::CMD_FAST);
    repeat (2) @(negedge mclk);
    chk({en_o, txd_o}, 2'b00);
    do @(negedge mclk); while (fast_on !== 1'b1);
    chk(en_o, 1'b1);
    wait_mode(lpmwc_pkg::ST_ACTIVE);
    send_cmd(lpmwc_pkg::CMD_FAST_EXIT);
    do @(negedge mclk); while (fast_on !== 1'b0);
    chk(slow_sel, 1'b0);
    @(posedge mclk);
    resetn <= 1'b0;
    @(negedge mclk);
    chk({en_o, txd_o, fast_on}, 3'b010);
    chk(mode, lpmwc_pkg::ST_AWAKE);
    complete_run();
  end
endmodule : lin_phy_mode_and_wake_control_test
`default_nettype wire
